// ==== mfab_pkg.sv ====
// mfab_pkg: constants, layouts and types of the flow action block
package mfab_pkg;
  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NUM_SA = 8; // flow action table depth
  localparam int IDX_W = 3; // index width
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_EGR_BASE = 12'h000; // egress_flow_action[]
  localparam logic [11:0] OFS_IGR_BASE = 12'h020; // ingress_flow_action[]
  localparam logic [11:0] OFS_NM_NCP = 12'h040; // non-control categories
  localparam logic [11:0] OFS_NM_CP = 12'h044; // control categories
  localparam logic [11:0] OFS_HDR_CFG = 12'h048; // header bypass setup
  localparam logic [11:0] OFS_MODE = 12'h04c; // direction
  localparam logic [11:0] OFS_PKT_CNT = 12'h050; // packets seen
  localparam logic [11:0] OFS_DROP_CNT = 12'h054; // packets dropped
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [31:0] RST_ACTION = 32'h0000_0000;
  localparam logic [31:0] RST_HDR_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_MODE = 32'h0000_0000;
  // ------------------------------------------------------------
  // header bypass: size in 2-byte units, 0 is off, 8 is 16 bytes
  // ------------------------------------------------------------
  localparam logic [3:0] HDR_UNITS_MAX = 4'h8;
  localparam logic [7:0] ETH_HDR_BYTES = 8'h0e; // da, sa, ethertype
  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  localparam logic [1:0] FT_BYPASS = 2'h0;
  localparam logic [1:0] FT_DROP = 2'h1;
  localparam logic [1:0] FT_PROCESS = 2'h2;
  localparam logic [1:0] PORT_COMMON = 2'h0;
  localparam logic [1:0] PORT_RESERVED = 2'h1;
  localparam logic [1:0] PORT_CONTROLLED = 2'h2;
  localparam logic [1:0] PORT_UNCONTROLLED = 2'h3;
  localparam logic [1:0] DM_CRC = 2'h0; // forward, corrupt crc
  localparam logic [1:0] DM_PKT_ERR = 2'h1; // forward, packet error
  localparam logic [1:0] DM_INTERNAL = 2'h2; // drop, nothing output
  localparam logic [1:0] TC_UNTAGGED = 2'h0;
  localparam logic [1:0] TC_TAGGED = 2'h1;
  localparam logic [1:0] TC_BAD_TAG = 2'h2;
  localparam logic [1:0] TC_KEY_AGREE = 2'h3;
  // ------------------------------------------------------------
  // one packet beat from flow lookup
  // ------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [63:0] data;
    logic sa_hit; // matched an enabled entry
    logic [IDX_W-1:0] sa_index; // matched entry
    logic control; // control packet class
    logic [1:0] tag_class; // tag classifier result
    logic [1:0] src_port; // source port
    logic [1:0] vlan_before_sectag; // parser tags ahead of sectag
    logic [15:0] second_ethertype; // header bypass ethertype
  } mfab_beat_in_s;
  // ------------------------------------------------------------
  // decoded action riding with each beat
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] flow_type;
    logic [1:0] dest_port;
    logic [1:0] drop_method;
    logic protect;
    logic association_active;
    logic sci_en;
    logic end_station_bit_en;
    logic scb_en;
    logic [1:0] bypass_tags;
    logic [6:0] conf_offset;
    logic conf_en;
    logic replay_en;
    logic [1:0] validate_level;
    logic [IDX_W-1:0] context_index; // transform record to use
    logic use_context;
    logic hdr_bypass;
    logic [7:0] sectag_pos; // byte offset of sectag
    logic ctrl_outer; // control detect on outer fields
    logic match_inner; // sa match on second ethertype path
  } mfab_action_s;
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [63:0] data;
    logic crc_corrupt;
    logic pkt_error;
    mfab_action_s act;
  } mfab_beat_out_s;
endpackage : mfab_pkg

// ==== mfab_flow_action.sv ====
// mfab_flow_action: per-SA flow action decode and bypass framing
`timescale 1ns/10ps
`default_nettype none
module mfab_flow_action
  import mfab_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i, // low freezes all state
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire mfab_beat_in_s beat_i, // from flow lookup
  output mfab_beat_out_s beat_o // toward transform and statistics
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [31:0] egr_act [NUM_SA]; // egress_flow_action table
  logic [31:0] igr_act [NUM_SA]; // ingress_flow_action table
  logic [31:0] nomatch_noncontrol_action; // byte per tag class
  logic [31:0] nomatch_control_action; // byte per tag class
  logic [3:0] hdr_units; // header size in 2-byte units
  logic [15:0] hdr_ethertype; // static second ethertype
  logic ingress_dir; // 1 ingress, 0 egress
  logic [31:0] pkt_cnt; // packets started
  logic [31:0] drop_cnt; // packets dropped
  mfab_action_s held_act; // action of packet in flight
  logic held_drop_int; // packet in flight dropped internally
  logic held_crc; // packet in flight gets crc corrupt
  logic held_err; // packet in flight gets error mark
  // ------------------------------------------------------------
  // address decode helpers
  // ------------------------------------------------------------
  // word hits inside a table of NUM_SA words at base
  function automatic logic tbl_hit(input logic [11:0] a,
                                   input logic [11:0] base);
    tbl_hit = (a[11:5] == base[11:5]) && (a[1:0] == 2'h0);
  endfunction : tbl_hit
  // register is mapped
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = tbl_hit(a, OFS_EGR_BASE) || tbl_hit(a, OFS_IGR_BASE) ||
              (a == OFS_NM_NCP) || (a == OFS_NM_CP) ||
              (a == OFS_HDR_CFG) || (a == OFS_MODE) ||
              (a == OFS_PKT_CNT) || (a == OFS_DROP_CNT);
  endfunction : addr_ok
  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  logic setup_ph; // setup cycle seen
  logic wr_fire; // write takes effect
  logic [IDX_W-1:0] widx; // table word index
  assign setup_ph = psel_i && !penable_i;
  assign wr_fire = psel_i && penable_i && pready_o && pwrite_i &&
                   addr_ok(paddr_i);
  assign widx = paddr_i[IDX_W+1:2];
  // ready one cycle after setup, so every access takes two cycles
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o <= setup_ph;
      pslverr_o <= setup_ph && !addr_ok(paddr_i);
    end
  end
  // read data captured in the setup cycle
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      if (setup_ph && !pwrite_i) begin
        if (tbl_hit(paddr_i, OFS_EGR_BASE)) begin
          prdata_o <= egr_act[widx];
        end else if (tbl_hit(paddr_i, OFS_IGR_BASE)) begin
          prdata_o <= igr_act[widx];
        end else begin
          case (paddr_i)
            OFS_NM_NCP: prdata_o <= nomatch_noncontrol_action;
            OFS_NM_CP: prdata_o <= nomatch_control_action;
            OFS_HDR_CFG: prdata_o <= {12'h000, hdr_units, hdr_ethertype};
            OFS_MODE: prdata_o <= {31'h0000_0000, ingress_dir};
            OFS_PKT_CNT: prdata_o <= pkt_cnt;
            OFS_DROP_CNT: prdata_o <= drop_cnt;
            default: prdata_o <= 32'h0000_0000; // unmapped
          endcase
        end
      end
    end
  end
  // flow action tables, written only at the completing edge
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_SA; i++) begin
        egr_act[i] <= RST_ACTION;
        igr_act[i] <= RST_ACTION;
      end
    end else if (ce_i && wr_fire) begin
      if (tbl_hit(paddr_i, OFS_EGR_BASE)) begin
        egr_act[widx] <= pwdata_i;
      end
      if (tbl_hit(paddr_i, OFS_IGR_BASE)) begin
        igr_act[widx] <= pwdata_i;
      end
    end
  end
  // static configuration registers
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      nomatch_noncontrol_action <= RST_ACTION;
      nomatch_control_action <= RST_ACTION;
      hdr_units <= RST_HDR_CFG[19:16];
      hdr_ethertype <= RST_HDR_CFG[15:0];
      ingress_dir <= RST_MODE[0];
    end else if (ce_i && wr_fire) begin
      case (paddr_i)
        OFS_NM_NCP: nomatch_noncontrol_action <= pwdata_i;
        OFS_NM_CP: nomatch_control_action <= pwdata_i;
        OFS_HDR_CFG: begin
          // sizes above 16 bytes clamp to 16
          hdr_units <= (pwdata_i[19:16] > HDR_UNITS_MAX) ?
                       HDR_UNITS_MAX : pwdata_i[19:16];
          hdr_ethertype <= pwdata_i[15:0];
        end
        OFS_MODE: ingress_dir <= pwdata_i[0];
        default: ; // tables handled elsewhere
      endcase
    end
  end
  // ------------------------------------------------------------
  // action decode at start of packet
  // ------------------------------------------------------------
  mfab_action_s next_act; // decoded action
  logic next_drop; // decoded drop decision
  logic [31:0] eword; // egress action of matched entry
  logic [31:0] iword; // ingress action of matched entry
  logic [7:0] nm_slot; // non-match category byte
  logic [1:0] tags_raw; // candidate bypassed tag count
  assign eword = egr_act[beat_i.sa_index];
  assign iword = igr_act[beat_i.sa_index];
  // category by control class and tag class, eight in all
  assign nm_slot = beat_i.control ?
    nomatch_control_action[{beat_i.tag_class, 3'h0} +: 8] :
    nomatch_noncontrol_action[{beat_i.tag_class, 3'h0} +: 8];
  always_comb begin
    next_act = '0;
    next_drop = 1'b0;
    tags_raw = 2'h0;
    if (beat_i.sa_hit) begin
      if (!ingress_dir) begin
        next_act.flow_type = eword[1:0];
        next_act.dest_port = eword[3:2];
        next_act.drop_method = eword[5:4];
        next_act.protect = eword[6];
        next_act.association_active = eword[7];
        next_act.sci_en = eword[8];
        next_act.end_station_bit_en = eword[9];
        next_act.scb_en = eword[10];
        tags_raw = eword[12:11];
        next_act.conf_offset = eword[19:13];
        next_act.conf_en = eword[20];
      end else begin
        next_act.flow_type = iword[1:0];
        next_act.dest_port = iword[3:2];
        next_act.drop_method = iword[5:4];
        next_act.replay_en = iword[7];
        next_act.association_active = iword[8];
        next_act.validate_level = iword[10:9];
        next_act.conf_offset = iword[17:11];
        // parser counts tags ahead of the sectag, may exceed two; clamped below
        tags_raw = beat_i.vlan_before_sectag;
        if (iword[6] && beat_i.src_port != PORT_RESERVED) begin
          next_act.flow_type = FT_DROP;
        end
      end
      // matched key agreement frames always pass untouched
      if (beat_i.tag_class == TC_KEY_AGREE) begin
        next_act.flow_type = FT_BYPASS;
      end
    end else begin
      // non-match: bit 0 drop, else pass; never processed
      next_act.flow_type = nm_slot[0] ? FT_DROP : FT_BYPASS;
      next_act.dest_port = nm_slot[2:1];
      next_act.drop_method = nm_slot[4:3];
    end
    // encoding 3 is unused and treated as drop for safety
    if (next_act.flow_type == 2'h3) begin
      next_act.flow_type = FT_DROP;
    end
    // zero keeps standard framing; above two clamps to two
    next_act.bypass_tags = (tags_raw > 2'h2) ? 2'h2 : tags_raw;
    // header bypass owns the port, no tag bypass beside it
    next_act.hdr_bypass = (hdr_units != 4'h0);
    if (next_act.hdr_bypass) begin
      next_act.bypass_tags = 2'h0;
      next_act.sectag_pos = ETH_HDR_BYTES +
                            {3'h0, hdr_units, 1'b0};
      // matching ethertype: outer addresses, else inner frame
      next_act.ctrl_outer =
        (beat_i.second_ethertype == hdr_ethertype);
      next_act.match_inner = 1'b1;
    end else begin
      // tags sit untouched ahead of the sectag
      next_act.sectag_pos = ETH_HDR_BYTES - 8'h02 +
                            {4'h0, next_act.bypass_tags, 2'h0};
      next_act.ctrl_outer = 1'b1;
      next_act.match_inner = 1'b0;
    end
    // transform record indexed by the matched entry
    next_act.use_context = (next_act.flow_type == FT_PROCESS);
    next_act.context_index = beat_i.sa_index;
    // without a context there is nothing to protect with
    if (next_act.flow_type != FT_PROCESS) begin
      next_act.protect = 1'b0;
    end
    next_drop = (next_act.flow_type == FT_DROP);
  end
  // ------------------------------------------------------------
  // per-packet hold: action is fixed from sop to eop
  // ------------------------------------------------------------
  logic sop_take; // first beat of a packet
  assign sop_take = beat_i.valid && beat_i.sop;
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      held_act <= '0;
      held_drop_int <= 1'b0;
      held_crc <= 1'b0;
      held_err <= 1'b0;
    end else if (ce_i && sop_take) begin
      held_act <= next_act;
      // drop method chosen at the start, before the end is seen
      held_drop_int <= next_drop &&
                       next_act.drop_method[1];
      held_crc <= next_drop &&
                  next_act.drop_method == DM_CRC;
      held_err <= next_drop &&
                  next_act.drop_method == DM_PKT_ERR;
    end
  end
  // ------------------------------------------------------------
  // output stage
  // ------------------------------------------------------------
  mfab_action_s cur_act; // action for this beat
  logic cur_int; // internal drop for this beat
  logic cur_crc; // crc corrupt for this beat
  logic cur_err; // error mark for this beat
  assign cur_act = sop_take ? next_act : held_act;
  assign cur_int = sop_take ? (next_drop && next_act.drop_method[1]) :
                   held_drop_int;
  assign cur_crc = sop_take ? (next_drop && next_act.drop_method ==
                   DM_CRC) : held_crc;
  assign cur_err = sop_take ? (next_drop && next_act.drop_method ==
                   DM_PKT_ERR) : held_err;
  // beats of an internally dropped packet never leave
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      beat_o <= '0;
    end else if (ce_i) begin
      beat_o.valid <= beat_i.valid && !cur_int;
      beat_o.sop <= beat_i.sop;
      beat_o.eop <= beat_i.eop;
      beat_o.data <= beat_i.data;
      // abort marks ride on the last beat toward the mac
      beat_o.crc_corrupt <= beat_i.eop && cur_crc;
      beat_o.pkt_error <= beat_i.eop && cur_err;
      beat_o.act <= cur_act;
    end
  end
  // ------------------------------------------------------------
  // status counters
  // ------------------------------------------------------------
  // packets started and packets dropped, wrapping
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      pkt_cnt <= 32'h0000_0000;
      drop_cnt <= 32'h0000_0000;
    end else if (ce_i && sop_take) begin
      pkt_cnt <= pkt_cnt + 32'h0000_0001;
      if (next_drop) begin
        drop_cnt <= drop_cnt + 32'h0000_0001;
      end
    end
  end
endmodule : mfab_flow_action
`default_nettype wire

// ==== mfab_flow_action_props.sv ====
// mfab_flow_action_props: port-level checks of the flow action block
`timescale 1ns/10ps
`default_nettype none
module mfab_flow_action_props
  import mfab_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire mfab_beat_in_s beat_i,
  input wire mfab_beat_out_s beat_o
);
  // ----
  // one clock domain, synchronous active-low reset
  // ----
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // setup answered in the next cycle
  property p_apb_answer;
    psel_i && !penable_i && ce_i |=> pready_o;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("no answer");
  // error comes with ready; a read then gives zero
  property p_err_answer;
    pslverr_o |-> pready_o && (pwrite_i || prdata_o == 32'h0);
  endproperty
  a_err_answer: assert property (p_err_answer) else $error("bad err");
  // packet start out one cycle later
  property p_beat_latency;
    ce_i && beat_i.valid && beat_i.sop |=> beat_o.sop;
  endproperty
  a_beat_latency: assert property (p_beat_latency)
    else $error("start lost");
  // action changes only at a packet start
  property p_act_hold;
    !beat_o.sop && $past(nrst_i) |-> $stable(beat_o.act);
  endproperty
  a_act_hold: assert property (p_act_hold)
    else $error("action moved mid packet");
  // an internal drop emits no valid beat
  property p_internal_silent;
    beat_o.act.flow_type == FT_DROP && beat_o.act.drop_method[1]
      |-> !beat_o.valid;
  endproperty
  a_internal_silent: assert property (p_internal_silent)
    else $error("internal drop leaked");
  // crc corruption only at packet end with the crc method
  property p_crc_cause;
    beat_o.crc_corrupt |-> beat_o.eop && beat_o.act.drop_method == DM_CRC;
  endproperty
  a_crc_cause: assert property (p_crc_cause)
    else $error("stray crc mark");
  // packet error only at packet end with the error method
  property p_err_cause;
    beat_o.pkt_error |-> beat_o.eop &&
      beat_o.act.drop_method == DM_PKT_ERR;
  endproperty
  a_err_cause: assert property (p_err_cause)
    else $error("stray error mark");
  // protection only on processed flows
  property p_protect;
    beat_o.act.protect |-> beat_o.act.flow_type == FT_PROCESS;
  endproperty
  a_protect: assert property (p_protect)
    else $error("protect outside process");
  // a context is fetched by the matched index
  property p_context;
    beat_o.sop && beat_o.act.use_context |->
      beat_o.act.context_index == $past(beat_i.sa_index);
  endproperty
  a_context: assert property (p_context)
    else $error("wrong context");
  // matched key frames bypassed
  property p_kay_bypass;
    ce_i && beat_i.valid && beat_i.sop && beat_i.sa_hit &&
      beat_i.tag_class == TC_KEY_AGREE |=> beat_o.act.flow_type == FT_BYPASS;
  endproperty
  a_kay_bypass: assert property (p_kay_bypass)
    else $error("key frame not bypassed");
  // tag bypass: at most two tags, sectag after them
  property p_tag_pos;
    beat_o.sop && !beat_o.act.hdr_bypass |-> beat_o.act.bypass_tags != 2'h3
      && beat_o.act.sectag_pos == 8'h0c + {beat_o.act.bypass_tags, 2'b00};
  endproperty
  a_tag_pos: assert property (p_tag_pos)
    else $error("tag position off");
  // header bypass: sectag after 2..16 even bytes
  property p_hdr_pos;
    beat_o.sop && beat_o.act.hdr_bypass |->
      beat_o.act.sectag_pos inside {[8'h10:8'h1e]} &&
      !beat_o.act.sectag_pos[0];
  endproperty
  a_hdr_pos: assert property (p_hdr_pos)
    else $error("header position off");
  // main scenarios reached
  c_crc: cover property (beat_o.crc_corrupt);
  c_hdr: cover property (beat_o.sop && beat_o.act.hdr_bypass);
  c_err: cover property (pslverr_o);
endmodule : mfab_flow_action_props
bind mfab_flow_action mfab_flow_action_props u_mfab_flow_action_props (
  .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .beat_i(beat_i), .beat_o(beat_o));
`default_nettype wire

// ==== mfab_lookup_model.sv ====
// mfab_lookup_model: flow lookup stage feeding packets to the block
`timescale 1ns/10ps
`default_nettype none
module mfab_lookup_model
  import mfab_pkg::*;
(
  input wire logic clock_i,
  output var mfab_beat_in_s beat_o
);
  initial beat_o = '0;
  // ----
  // three-beat packet, class held throughout
  // ----
  task automatic send(input logic hit, input logic [IDX_W-1:0] idx,
    input logic ctrl, input logic [1:0] tc, input logic [1:0] src,
    input logic [1:0] vlan, input logic [15:0] et);
    int i;
    for (i = 0; i < 3; i++) begin
      @(posedge clock_i);
      beat_o.valid <= 1'b1;
      beat_o.sop <= (i == 0);
      beat_o.eop <= (i == 2);
      beat_o.data <= 64'h0123_4567_89ab_cdef ^ 64'(i);
      beat_o.sa_hit <= hit;
      // no hit: index built from the category
      beat_o.sa_index <= hit ? idx : {ctrl, tc};
      beat_o.control <= ctrl;
      beat_o.tag_class <= tc;
      beat_o.src_port <= src;
      beat_o.vlan_before_sectag <= vlan;
      beat_o.second_ethertype <= et;
    end
    // idle: strobes drop, data inverted once and then held
    @(posedge clock_i);
    beat_o.valid <= 1'b0;
    beat_o.sop <= 1'b0;
    beat_o.eop <= 1'b0;
    beat_o.data <= ~beat_o.data;
    repeat (2) @(posedge clock_i);
  endtask : send
endmodule : mfab_lookup_model
`default_nettype wire

// ==== mfab_flow_action_test.sv ====
// mfab_flow_action_test: self-checking bench of the flow action block
`timescale 1ns/10ps
`default_nettype none
module mfab_flow_action_test
  import mfab_pkg::*;
;
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
  // ----
  // stimulus, outputs, captured results
  // ----
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1; // held running throughout
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  mfab_beat_in_s beat_i;
  mfab_beat_out_s beat_o;
  int fails = 0;
  int n_tests = 0;
  logic [31:0] rd; // last read data
  logic er; // last error answer
  mfab_action_s s_act; // action seen at packet start
  logic e_crc, e_err, e_valid;
  always #2.5 clock_i = ~clock_i;
  mfab_flow_action u_mfab_flow_action (.clock_i(clock_i), .nrst_i(nrst_i),
    .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .beat_i(beat_i), .beat_o(beat_o));
  mfab_lookup_model u_mfab_lookup_model (.clock_i(clock_i), .beat_o(beat_i));
  // capture start and end of each packet
  always @(posedge clock_i) begin
    if (beat_o.sop) begin
      s_act <= beat_o.act;
    end
    if (beat_o.eop) begin
      e_crc <= beat_o.crc_corrupt;
      e_err <= beat_o.pkt_error;
      e_valid <= beat_o.valid;
    end
  end
  // ----
  // apb transfer: setup, access until pready
  // ----
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  // reset values, read-back and an unmapped word
  task automatic t_regs();
    apb(1'b0, OFS_EGR_BASE, 32'h0);
    `CHK(rd, RST_ACTION);
    apb(1'b0, OFS_HDR_CFG, 32'h0);
    `CHK(rd, RST_HDR_CFG);
    apb(1'b0, OFS_MODE, 32'h0);
    `CHK(rd, RST_MODE);
    apb(1'b1, OFS_EGR_BASE + 12'h01c, 32'h001f_ffff);
    apb(1'b0, OFS_EGR_BASE + 12'h01c, 32'h0);
    `CHK(rd, 32'h001f_ffff);
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0});
    $display("test regs done");
  endtask : t_regs
  // egress action fields, tag count zero, key agreement bypass
  task automatic t_egress();
    logic [31:0] w;
    w = {11'h0, 1'b1, 7'h35, 2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1,
      DM_PKT_ERR, PORT_CONTROLLED, FT_PROCESS};
    apb(1'b1, OFS_EGR_BASE + 12'h00c, w);
    u_mfab_lookup_model.send(1'b1, 3'h3, 1'b0, TC_UNTAGGED, 2'h0, 2'h0, 16'h0);
    `CHK({s_act.conf_en, s_act.conf_offset, s_act.bypass_tags, s_act.scb_en,
      s_act.end_station_bit_en, s_act.sci_en, s_act.association_active,
      s_act.protect, s_act.drop_method, s_act.dest_port, s_act.flow_type},
      w[20:0]);
    `CHK({s_act.use_context, s_act.context_index}, 4'hb);
    `CHK(s_act.sectag_pos, 8'h14);
    apb(1'b1, OFS_EGR_BASE + 12'h008, w & ~32'h0000_1800);
    u_mfab_lookup_model.send(1'b1, 3'h2, 1'b0, TC_UNTAGGED, 2'h0, 2'h2, 16'h0);
    `CHK({s_act.bypass_tags, s_act.sectag_pos}, 10'h00c);
    u_mfab_lookup_model.send(1'b1, 3'h3, 1'b0, TC_KEY_AGREE, 2'h0, 2'h0, 16'h0);
    `CHK({s_act.flow_type, s_act.protect}, {FT_BYPASS, 1'b0});
    $display("test egress done");
  endtask : t_egress
  // every drop method, plus the spare flow type code
  task automatic t_drop();
    int m;
    for (m = 0; m < 4; m++) begin
      apb(1'b1, OFS_EGR_BASE + 12'h004,
        {26'h0, m[1:0], PORT_COMMON, (m == 3) ? 2'h3 : FT_DROP});
      u_mfab_lookup_model.send(1'b1, 3'h1, 1'b0, TC_UNTAGGED, 2'h0, 2'h0,
        16'h0);
      `CHK({e_crc, e_err}, {m == 0, m == 1});
      `CHK(e_valid, m < 2);
    end
    $display("test drop done");
  endtask : t_drop
  // ingress fields and drop of non-reserved sources
  task automatic t_ingress();
    logic [31:0] w;
    w = {14'h0, 7'h11, 2'h2, 1'b1, 1'b1, 1'b1, DM_CRC, PORT_UNCONTROLLED,
      FT_PROCESS};
    apb(1'b1, OFS_MODE, 32'h1);
    apb(1'b1, OFS_IGR_BASE + 12'h014, w);
    u_mfab_lookup_model.send(1'b1, 3'h5, 1'b0, TC_TAGGED, PORT_COMMON, 2'h1,
      16'h0);
    `CHK({s_act.conf_offset, s_act.validate_level, s_act.replay_en,
      s_act.association_active}, {7'h11, 2'h2, 2'h3});
    `CHK(s_act.dest_port, PORT_UNCONTROLLED);
    `CHK({s_act.bypass_tags, s_act.sectag_pos}, 10'h110);
    `CHK(e_crc, 1'b1);
    u_mfab_lookup_model.send(1'b1, 3'h5, 1'b0, TC_TAGGED, PORT_RESERVED,
      2'h3, 16'h0);
    `CHK({s_act.bypass_tags, e_crc, e_valid}, 4'h9);
    apb(1'b1, OFS_MODE, 32'h0);
    $display("test ingress done");
  endtask : t_ingress
  // all eight non-match categories
  task automatic t_nomatch();
    logic [31:0] ncp, cp;
    int c, t;
    logic dr;
    for (t = 0; t < 4; t++) begin
      ncp[t*8 +: 8] = {3'h0, DM_CRC, t[1:0], t[0]};
      cp[t*8 +: 8] = {3'h0, DM_PKT_ERR, t[1:0], ~t[0]};
    end
    apb(1'b1, OFS_NM_NCP, ncp);
    apb(1'b1, OFS_NM_CP, cp);
    for (c = 0; c < 2; c++) begin
      for (t = 0; t < 4; t++) begin
        u_mfab_lookup_model.send(1'b0, 3'h0, c[0], t[1:0], 2'h0, 2'h0, 16'h0);
        dr = c[0] ? ~t[0] : t[0];
        `CHK(s_act.dest_port, t[1:0]);
        `CHK({e_crc, e_err}, {dr & ~c[0], dr & c[0]});
      end
    end
    $display("test nomatch done");
  endtask : t_nomatch
  // header bypass size, sectag position, control detect path
  task automatic t_hdr();
    apb(1'b1, OFS_HDR_CFG, {12'h0, 4'hf, 16'h8847});
    u_mfab_lookup_model.send(1'b1, 3'h3, 1'b0, TC_TAGGED, 2'h0, 2'h0, 16'h8847);
    `CHK({s_act.hdr_bypass, s_act.sectag_pos}, 9'h11e);
    `CHK(s_act.bypass_tags, 2'h0);
    `CHK({s_act.ctrl_outer, s_act.match_inner}, 2'h3);
    apb(1'b1, OFS_HDR_CFG, {12'h0, 4'h1, 16'h8847});
    u_mfab_lookup_model.send(1'b1, 3'h3, 1'b0, TC_TAGGED, 2'h0, 2'h0, 16'h0800);
    `CHK({s_act.ctrl_outer, s_act.sectag_pos}, 9'h010);
    apb(1'b1, OFS_HDR_CFG, 32'h0000_8847);
    u_mfab_lookup_model.send(1'b1, 3'h3, 1'b0, TC_TAGGED, 2'h0, 2'h0, 16'h8847);
    `CHK(s_act.hdr_bypass, 1'b0);
    $display("test header done");
  endtask : t_hdr
  // main sequence
  initial begin
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_regs();
    t_egress();
    t_drop();
    t_ingress();
    t_nomatch();
    t_hdr();
    test_done();
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clock_i);
    fails++;
    test_done();
  end
endmodule : mfab_flow_action_test
`default_nettype wire
